// ---- oid_pkg.sv ----
// Constants and types shared by the open-input detector files
package oid_pkg;

    // Channel count and conversion code width
    localparam int NCH = 8;
    localparam int CODE_W = 18;

    // Register indices; the byte address on the bus is four times these
    localparam logic [7:0] IDX_ENABLE = 8'h23;
    localparam logic [7:0] IDX_FLAGS = 8'h24;
    localparam logic [7:0] IDX_COUNT = 8'h2c;
    localparam logic [7:0] IDX_MASK = 8'h30;
    localparam logic [7:0] IDX_STATE = 8'h31;

    // Byte addresses on the register bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_ENABLE = {IDX_ENABLE[5:0], 2'b00};
    localparam logic [7:0] ADDR_FLAGS = {IDX_FLAGS[5:0], 2'b00};
    localparam logic [7:0] ADDR_COUNT = {IDX_COUNT[5:0], 2'b00};
    localparam logic [7:0] ADDR_MASK = {IDX_MASK[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATE = {IDX_STATE[5:0], 2'b00};

    // Reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Count register decode
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] MODE_MANUAL = 8'h01;

    // Field positions in the state register
    localparam int ST_SWMODE_BIT = 8;
    localparam int ST_AUTO_BIT = 9;
    localparam int ST_MANUAL_BIT = 10;
    localparam int ST_IRQ_BIT = 11;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Automatic check sequencer, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETTLE = 4'h2,
        ST_SAMPLE = 4'h4,
        ST_RESTORE = 4'h8
    } oid_state_t;

endpackage : oid_pkg

// ---- oid_ctl_if.sv ----
// Control bundle from the check sequencer to the channel trackers
`timescale 1ns/1ns
`default_nettype none
interface oid_ctl_if;
    logic conv_valid;
    logic auto_mode;
    logic [7:0] threshold;
    logic sample_now;
    logic check_end;

    modport ctl (output conv_valid, auto_mode, threshold, sample_now,
        check_end);
    modport chan (input conv_valid, auto_mode, threshold, sample_now,
        check_end);
endinterface : oid_ctl_if
`default_nettype wire

// ---- oid_channel.sv ----
// One channel: unchanged-code counter and shifted-code comparison
`timescale 1ns/1ns
`default_nettype none
module oid_channel (
    input wire logic aclk,
    input wire logic aresetn,
    oid_ctl_if.chan ctl,
    input wire logic [oid_pkg::CODE_W-1:0] code,
    input wire logic armed,
    input wire logic in_check,
    output logic req,
    output logic open_evt
);
    logic [oid_pkg::CODE_W-1:0] prev_r;
    logic [7:0] count_r;

    // Previous code is frozen during a check so it serves as reference
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= '0;
        end else if (ctl.conv_valid && (!in_check || ctl.check_end)) begin
            prev_r <= code;
        end
    end

    // Unchanged-conversion counter, saturating at the threshold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= 8'h00;
        end else if (!armed || ctl.check_end) begin
            count_r <= 8'h00;
        end else if (ctl.conv_valid && !in_check) begin
            if (code != prev_r) begin
                count_r <= 8'h00;
            end else if (count_r < ctl.threshold) begin
                count_r <= count_r + 8'h01;
            end
        end
    end

    // Request a check once enough repeats are seen
    assign req = armed && ctl.auto_mode && !in_check &&
        (count_r >= ctl.threshold);
    // Code moved with the common mode shifted: input is open
    assign open_evt = in_check && ctl.sample_now &&
        (code != prev_r);
endmodule : oid_channel
`default_nettype wire

// ---- oid_irq.sv ----
// Sticky open flags, read-to-clear, masked onto one interrupt level
`timescale 1ns/1ns
`default_nettype none
module oid_irq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] set_evt,
    input wire logic rd_clr,
    input wire logic [7:0] mask,
    output logic [7:0] status,
    output logic irq
);
    logic [7:0] status_nxt;

    // New events win over a clearing read in the same cycle
    assign status_nxt = (rd_clr ? 8'h00 : status) | set_evt;

    // Sticky flag storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= oid_pkg::FLAGS_RST;
        end else begin
            status <= status_nxt;
        end
    end

    // Registered interrupt level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_nxt & mask);
        end
    end
endmodule : oid_irq
`default_nettype wire

// ---- oid_top.sv ----
// Open-input detector: register slave, mode decode and check sequencer
// Functional notes
// - A count register value above one selects automatic detection.
// - Count zero disables, one is manual, two upward is automatic.
// - In automatic mode the count is the repeats needed before a check starts.
// - Enough unchanged codes start a check with no software command.
// - A check shifts common mode, samples output, then restores it.
// - A code change under shifted common mode sets that channel's flag.
// - Per-channel enable bits select which channels are checked.
// - Registers are reachable only while all oversampling pins are high.
// - In manual mode each enable bit drives its common-mode shift.
// - Detection only acts on channels set to bipolar ranges.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module oid_top (
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [oid_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [oid_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter side
    input wire logic [2:0] oversampling_select_pins,
    input wire logic [7:0] channel_bipolar,
    input wire logic conv_valid,
    input wire logic [oid_pkg::NCH*oid_pkg::CODE_W-1:0] conv_codes,
    output logic [7:0] cm_shift,
    output logic irq
);
    // Register and bus state
    logic [7:0] enable_r;
    logic [7:0] count_r;
    logic [7:0] mask_r;
    logic aw_full_r;
    logic [oid_pkg::ADDR_W-1:0] awaddr_r;
    logic w_full_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] cm_shift_r;

    // Sequencer state
    oid_pkg::oid_state_t state_r;
    oid_pkg::oid_state_t state_nxt;
    logic [7:0] sel_r;
    logic [7:0] sel_nxt;

    // Decode and handshake terms
    logic sw_mode;
    logic auto_mode;
    logic manual_mode;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_do;
    logic aw_full_nxt;
    logic w_full_nxt;
    logic rvalid_nxt;
    logic flags_rd_clr;
    logic [7:0] armed;
    logic [7:0] req;
    logic [7:0] open_evt;
    logic [7:0] flags;
    logic irq_w;

    oid_ctl_if ctl ();

    // Registers open only in software mode
    assign sw_mode = &oversampling_select_pins;

    // Count register doubles as mode select
    assign auto_mode = (count_r > oid_pkg::MODE_MANUAL);
    assign manual_mode = (count_r == oid_pkg::MODE_MANUAL);

    // Only enabled bipolar channels take part in automatic checks
    assign armed = enable_r & channel_bipolar
        & {8{auto_mode}};

    // Handshakes on the bus
    assign aw_hs = s_axi_awvalid && awready_r;
    assign w_hs = s_axi_wvalid && wready_r;
    assign ar_hs = s_axi_arvalid && arready_r;
    assign wr_do = aw_full_r && w_full_r && !bvalid_r;

    // Address and data may arrive in either order
    assign aw_full_nxt = wr_do ? 1'b0 : (aw_full_r || aw_hs);
    assign w_full_nxt = wr_do ? 1'b0 : (w_full_r || w_hs);
    assign rvalid_nxt = ar_hs ? 1'b1 : (rvalid_r && !s_axi_rready);

    // Flags clear on an accepted read of the flag register
    assign flags_rd_clr = ar_hs && sw_mode &&
        (s_axi_araddr == oid_pkg::ADDR_FLAGS);

    // Write channel holding registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            awaddr_r <= '0;
            w_full_r <= 1'b0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
        end
    end

    // Ready flags come from flops; one write is held at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            arready_r <= 1'b0;
        end else begin
            awready_r <= !aw_full_nxt;
            wready_r <= !w_full_nxt;
            arready_r <= !rvalid_nxt;
        end
    end

    // Write response; outside software mode the write is refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= oid_pkg::RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            if (!sw_mode) begin
                bresp_r <= oid_pkg::RESP_SLVERR;
            end else begin
                case (awaddr_r)
                    oid_pkg::ADDR_ENABLE,
                    oid_pkg::ADDR_COUNT,
                    oid_pkg::ADDR_MASK,
                    oid_pkg::ADDR_FLAGS,
                    oid_pkg::ADDR_STATE: begin
                        bresp_r <= oid_pkg::RESP_OKAY;
                    end
                    default: begin
                        bresp_r <= oid_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Writable registers; flag and state words are read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= oid_pkg::ENABLE_RST;
            count_r <= oid_pkg::COUNT_RST;
            mask_r <= oid_pkg::MASK_RST;
        end else if (wr_do && sw_mode && wstrb0_r) begin
            case (awaddr_r)
                oid_pkg::ADDR_ENABLE: begin
                    enable_r <= wdata_r;
                end
                oid_pkg::ADDR_COUNT: begin
                    count_r <= wdata_r;
                end
                oid_pkg::ADDR_MASK: begin
                    mask_r <= wdata_r;
                end
                default: begin
                    enable_r <= enable_r;
                end
            endcase
        end
    end

    // Read data is captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= oid_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            if (ar_hs) begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= oid_pkg::RESP_OKAY;
                if (!sw_mode) begin
                    rresp_r <= oid_pkg::RESP_SLVERR;
                end else begin
                    case (s_axi_araddr)
                        oid_pkg::ADDR_ENABLE: begin
                            rdata_r[7:0] <= enable_r;
                        end
                        oid_pkg::ADDR_FLAGS: begin
                            rdata_r[7:0] <= flags;
                        end
                        oid_pkg::ADDR_COUNT: begin
                            rdata_r[7:0] <= count_r;
                        end
                        oid_pkg::ADDR_MASK: begin
                            rdata_r[7:0] <= mask_r;
                        end
                        oid_pkg::ADDR_STATE: begin
                            rdata_r[3:0] <= state_r;
                            rdata_r[oid_pkg::ST_SWMODE_BIT] <= sw_mode;
                            rdata_r[oid_pkg::ST_AUTO_BIT] <= auto_mode;
                            rdata_r[oid_pkg::ST_MANUAL_BIT] <= manual_mode;
                            rdata_r[oid_pkg::ST_IRQ_BIT] <= irq_w;
                        end
                        default: begin
                            rresp_r <= oid_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
        end
    end

    // Check sequencer: shift, let it settle, sample, restore and settle
    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        case (state_r)
            oid_pkg::ST_IDLE: begin
                if (|req) begin
                    state_nxt = oid_pkg::ST_SETTLE;
                    sel_nxt = req;
                end
            end
            oid_pkg::ST_SETTLE: begin
                // First conversion after the shift may predate it
                if (!auto_mode) begin
                    state_nxt = oid_pkg::ST_RESTORE;
                end else if (conv_valid) begin
                    state_nxt = oid_pkg::ST_SAMPLE;
                end
            end
            oid_pkg::ST_SAMPLE: begin
                if (!auto_mode || conv_valid) begin
                    state_nxt = oid_pkg::ST_RESTORE;
                end
            end
            oid_pkg::ST_RESTORE: begin
                // One conversion at normal common mode resyncs channels
                if (conv_valid) begin
                    state_nxt = oid_pkg::ST_IDLE;
                    sel_nxt = 8'h00;
                end
            end
            default: begin
                state_nxt = oid_pkg::ST_IDLE;
                sel_nxt = 8'h00;
            end
        endcase
    end

    // Sequencer state flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= oid_pkg::ST_IDLE;
            sel_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
        end
    end

    // Common-mode drive: manual follows enable bits, automatic the check
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cm_shift_r <= 8'h00;
        end else if (manual_mode) begin
            cm_shift_r <= enable_r & channel_bipolar;
        end else if (state_nxt == oid_pkg::ST_SETTLE ||
                state_nxt == oid_pkg::ST_SAMPLE) begin
            cm_shift_r <= sel_nxt & channel_bipolar;
        end else begin
            cm_shift_r <= 8'h00;
        end
    end

    // Shared control to the channel trackers
    assign ctl.conv_valid = conv_valid;
    assign ctl.auto_mode = auto_mode;
    assign ctl.threshold = count_r;
    assign ctl.sample_now = conv_valid && state_r == oid_pkg::ST_SAMPLE
        && auto_mode;
    assign ctl.check_end = conv_valid &&
        state_r == oid_pkg::ST_RESTORE;

    // One tracker per channel
    for (genvar i = 0; i < oid_pkg::NCH; i++) begin : g_chan
        oid_channel u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .ctl(ctl.chan),
            .code(conv_codes[i*oid_pkg::CODE_W +: oid_pkg::CODE_W]),
            .armed(armed[i]),
            .in_check(sel_r[i]),
            .req(req[i]),
            .open_evt(open_evt[i])
        );
    end

    // Open flags and the interrupt
    oid_irq u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_evt(open_evt),
        .rd_clr(flags_rd_clr),
        .mask(mask_r),
        .status(flags),
        .irq(irq_w)
    );

    // Port drive
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign cm_shift = cm_shift_r;
    assign irq = irq_w;
endmodule : oid_top
`default_nettype wire

// ---- oid_checker.sv ----
// Port-level assertions for the open-input detector
`timescale 1ns/1ns
`default_nettype none
module oid_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [oid_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [2:0] oversampling_select_pins,
    input wire logic [7:0] channel_bipolar,
    input wire logic conv_valid,
    input wire logic [7:0] cm_shift,
    input wire logic irq
);
    logic sw_mode;
    logic wr_hs;
    logic any_cm;
    logic [7:0] count_r;
    logic [7:0] en_r;
    // Accepted writes; the mode is not visible at the ports otherwise
    assign sw_mode = oversampling_select_pins == 3'h7;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && sw_mode && s_axi_wstrb[0];
    assign any_cm = |cm_shift;
    // Shadow copies of count and enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= 8'h00;
            en_r <= 8'h00;
        end else if (wr_hs) begin
            if (s_axi_awaddr == oid_pkg::ADDR_COUNT) count_r <= s_axi_wdata[7:0];
            if (s_axi_awaddr == oid_pkg::ADDR_ENABLE) en_r <= s_axi_wdata[7:0];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    refused_read_a: assert property (
        s_axi_arvalid && s_axi_arready && !sw_mode |=> s_axi_rvalid
        && s_axi_rresp == oid_pkg::RESP_SLVERR && s_axi_rdata == 32'h0
    ) else $error("read outside software mode not refused");
    refused_write_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !sw_mode |=> ##1 s_axi_bvalid && s_axi_bresp == oid_pkg::RESP_SLVERR
    ) else $error("write outside software mode not refused");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    ) else $error("read answer late");
    disabled_idle_a: assert property (
        count_r == 8'h00 && $past(count_r, 2) == 8'h00 |-> cm_shift == 8'h00
    ) else $error("common mode shifted while disabled");
    manual_follow_a: assert property (
        count_r == 8'h01 && $past(count_r, 2) == 8'h01
        |-> cm_shift == ($past(en_r, 2) & $past(channel_bipolar))
    ) else $error("manual shift does not follow enable");
    unipolar_quiet_a: assert property (
        (cm_shift & ~$past(channel_bipolar)) == 8'h00
    ) else $error("unipolar channel shifted");
    shift_restore_a: assert property (
        count_r > 8'h01 && $rose(any_cm) |-> ##[1:40] !any_cm
    ) else $error("automatic shift not restored");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(conv_valid) || $past(wr_hs, 3)
    ) else $error("interrupt rose without cause");
endmodule : oid_checker
bind oid_top oid_checker oid_checker_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .oversampling_select_pins, .channel_bipolar,
    .conv_valid, .cm_shift, .irq
);
`default_nettype wire

// ---- oid_source_model.sv ----
// Converter inputs: sources, some opened onto their pull-downs
`timescale 1ns/1ns
`default_nettype none
module oid_source_model #(
    parameter int PERIOD = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [oid_pkg::NCH*oid_pkg::CODE_W-1:0] base,
    input wire logic [7:0] open_mask,
    input wire logic [7:0] cm_shift,
    output logic conv_valid,
    output logic [oid_pkg::NCH*oid_pkg::CODE_W-1:0] conv_codes
);
    localparam int W = oid_pkg::CODE_W;
    logic [7:0] tick_r;
    logic [oid_pkg::NCH*W-1:0] held_r;
    // Codes are garbage outside the conversion cycle
    assign conv_codes = conv_valid ? held_r : ~held_r;
    // One conversion pulse every PERIOD cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_r <= 8'h00;
            conv_valid <= 1'b0;
        end else begin
            tick_r <= (tick_r == 8'(PERIOD - 1)) ? 8'h00 : tick_r + 8'h01;
            conv_valid <= tick_r == 8'h00;
        end
    end
    // Instant settling, so any count from the settling sums suffices
    always_ff @(posedge aclk) begin
        for (int i = 0; i < oid_pkg::NCH; i++) begin
            held_r[i*W +: W] <= base[i*W +: W]
                + ((open_mask[i] && cm_shift[i]) ? 18'h00100 : 18'h00000);
        end
    end
endmodule : oid_source_model
`default_nettype wire

// ---- open_input_detector_test.sv ----
// Self-checking bench for the open-input detector
`timescale 1ns/1ns
`default_nettype none
module open_input_detector_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, conv_valid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, bus_resp;
    logic [31:0] s_axi_rdata;
    logic [2:0] oversampling_select_pins = 3'h7;
    logic [7:0] channel_bipolar = 8'hff, open_mask = 8'h00;
    logic [7:0] cm_shift, bus_data;
    logic [143:0] base = 144'h0, conv_codes;
    int err_count = 0, checked = 0, cycles = 0;
    oid_top oid_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oversampling_select_pins,
        .channel_bipolar, .conv_valid, .conv_codes, .cm_shift, .irq);
    oid_source_model oid_source_model_inst (.aclk, .aresetn, .base,
        .open_mask, .cm_shift, .conv_valid, .conv_codes);
    // 25 MHz clock
    initial begin
        forever #20 aclk = ~aclk;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // Write with address and data offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        bus_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        bus_resp = s_axi_rresp;
        bus_data = s_axi_rdata[7:0];
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wait_conv(input int n);
        repeat (n) begin
            do @(posedge aclk); while (!conv_valid);
        end
    endtask : wait_conv
    function automatic logic [7:0] exp_flags(input logic [7:0] en, bip, op);
        return en & bip & op;
    endfunction : exp_flags
    initial begin
        logic [7:0] en, bip, op, ex;
        static logic [7:0] counts [3] = '{8'h06, 8'h07, 8'h09};
        static logic [7:0] addrs [4] = '{oid_pkg::ADDR_ENABLE,
            oid_pkg::ADDR_FLAGS, oid_pkg::ADDR_COUNT, oid_pkg::ADDR_MASK};
        void'($urandom(87546));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (addrs[i]) begin
            rd(addrs[i]);
            check("reset value", bus_data, 8'h00);
        end
        // Unmapped word, then every pin code outside software mode
        rd(8'hfc);
        check("unmapped resp", {6'h00, bus_resp}, 8'h02);
        for (int p = 0; p < 7; p++) begin
            oversampling_select_pins <= 3'(p);
            wr(oid_pkg::ADDR_COUNT, 8'h05);
            check("locked write", {6'h00, bus_resp}, 8'h02);
            rd(oid_pkg::ADDR_COUNT);
            check("locked read", {6'h00, bus_resp}, 8'h02);
        end
        oversampling_select_pins <= 3'h7;
        rd(oid_pkg::ADDR_COUNT);
        check("count kept", bus_data, 8'h00);
        wr(oid_pkg::ADDR_FLAGS, 8'hff);
        rd(oid_pkg::ADDR_FLAGS);
        check("flags read-only", bus_data, 8'h00);
        // Manual mode with random enables and ranges
        wr(oid_pkg::ADDR_COUNT, 8'h01);
        for (int k = 0; k < 4; k++) begin
            en = 8'($urandom);
            bip = 8'($urandom);
            channel_bipolar <= bip;
            wr(oid_pkg::ADDR_ENABLE, en);
            repeat (3) @(posedge aclk);
            check("manual shift", cm_shift, en & bip);
        end
        wr(oid_pkg::ADDR_COUNT, 8'h00);
        wait_conv(2);
        check("disabled shift", cm_shift, 8'h00);
        for (int i = 0; i < 8; i++) base[i*18 +: 18] <= 18'($urandom);
        // Automatic rounds; first round is all channels, all open
        foreach (counts[k]) begin
            en = (k == 0) ? 8'hff : 8'($urandom) | 8'h01;
            bip = (k == 0) ? 8'hff : 8'($urandom) | 8'h01;
            op = (k == 0) ? 8'hff : 8'($urandom);
            ex = exp_flags(en, bip, op);
            channel_bipolar <= bip;
            open_mask <= op;
            wr(oid_pkg::ADDR_MASK, 8'h00);
            wr(oid_pkg::ADDR_ENABLE, en);
            wr(oid_pkg::ADDR_COUNT, counts[k]);
            rd(oid_pkg::ADDR_STATE);
            check("state", bus_data, 8'h01);
            check("state modes", s_axi_rdata[15:8], 8'h03);
            for (int i = 0; i < 8; i++) begin
                base[i*18 +: 18] <= base[i*18 +: 18] + 18'h00001;
            end
            wait_conv(counts[k]);
            repeat (3) @(posedge aclk);
            check("early shift", cm_shift, 8'h00);
            wait_conv(2);
            repeat (3) @(posedge aclk);
            check("auto shift", cm_shift, en & bip);
            wait_conv(4);
            repeat (3) @(posedge aclk);
            check("restored", cm_shift, 8'h00);
            wr(oid_pkg::ADDR_COUNT, 8'h00);
            check("masked irq", {7'h00, irq}, 8'h00);
            wr(oid_pkg::ADDR_MASK, 8'hff);
            repeat (3) @(posedge aclk);
            check("irq level", {7'h00, irq}, {7'h00, |ex});
            rd(oid_pkg::ADDR_FLAGS);
            check("open flags", bus_data, ex);
            repeat (3) @(posedge aclk);
            check("irq cleared", {7'h00, irq}, 8'h00);
            rd(oid_pkg::ADDR_FLAGS);
            check("flags cleared", bus_data, 8'h00);
        end
        tally_and_finish();
    end
endmodule : open_input_detector_test
`default_nettype wire
